//--- tod_loadstore.sv
// Top of the time-of-day block: three domain counters, trim generators,
// five load/store controllers and the register port.
// Assumes pins are asynchronous and software enables the pin overlay first.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "tod_consts.svh"
module tod_loadstore
#(
    parameter int NUM_CTRL = `NUM_CTRL,
    parameter int NUM_PINS = `NUM_PINS,
    parameter int NUM_DOM  = `NUM_DOM
)
(
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Register port.
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata_ff,
    // Synchronisation pins, three signals each.
    input  wire logic [NUM_PINS-1:0]  sync_pin_in,
    output logic [NUM_PINS-1:0]       sync_pin_out_ff,
    output logic [NUM_PINS-1:0]       sync_pin_oe_n_ff,
    // Event flags after mask, one per controller.
    output logic [NUM_CTRL-1:0]       ctrl_event_ff,
    // Time of domain zero for consumers.
    output logic [`SEC_W-1:0]         time_seconds_value_ff,
    output logic [`NS_W-1:0]          time_nanoseconds_value_ff
);
    import tod_pkg::*;

    // -------------------------------------------------------------------------
    // Shared state
    // -------------------------------------------------------------------------
    logic [`SEC_W-1:0] dom_sec  [NUM_DOM];
    logic [`NS_W-1:0]  dom_ns   [NUM_DOM];
    logic [`NSF_W-1:0] free_running_ns_timer_ff;
    logic [NUM_PINS-1:0] pin_s1_ff;
    logic [NUM_PINS-1:0] pin_s2_ff;
    logic [NUM_PINS-1:0] pin_s3_ff;
    logic [NUM_CTRL-1:0] evt_stat_ff;
    logic [NUM_CTRL-1:0] evt_mask_ff;
    logic [NUM_CTRL-1:0] evt_set;
    logic [31:0]         port_dom_ff;
    logic [31:0]         rd_mux;
    logic [NUM_DOM-1:0]  dom_abs;
    logic [NUM_DOM-1:0]  dom_add;
    logic [`SEC_W-1:0]   dom_set_sec [NUM_DOM];
    logic [`NS_W-1:0]    dom_set_ns  [NUM_DOM];
    logic [31:0]         ctrl_rd [NUM_CTRL];
    logic [31:0]         dom_rd  [NUM_DOM];
    logic [NUM_CTRL-1:0] ld_req;
    logic [NUM_CTRL-1:0] dl_req;
    logic [1:0]          ctrl_dom [NUM_CTRL];
    logic [`SEC_W-1:0]   ctrl_sec [NUM_CTRL];
    logic [`NS_W-1:0]    ctrl_dns [NUM_CTRL];
    logic [`NS_W-1:0]    ctrl_ns  [NUM_CTRL];

    wire logic rd_evt  = reg_addr == `A_EVT_STAT;
    wire logic wr_evt  = reg_wr && rd_evt;
    wire logic wr_mask = reg_wr && (reg_addr == `A_EVT_MASK);
    wire logic wr_pdom = reg_wr && (reg_addr == `A_PORT_DOM);

    // Pin synchronisers; the third stage gives the previous level for edges.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= sync_pin_in;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // Free-running timer; it has no load path at all.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            free_running_ns_timer_ff <= '0;
        else
            free_running_ns_timer_ff <= free_running_ns_timer_ff + `NSF_W'(`CLK_PERIOD_NS);  // RL8
    end

    // -------------------------------------------------------------------------
    // Time domains with their trim generators
    // -------------------------------------------------------------------------
    genvar d;
    generate
        for (d = 0; d < NUM_DOM; d++)
        begin : g_dom
            logic [1:0]  adj_cfg_ff;
            logic [31:0] adj_int_ff;
            logic [31:0] adj_cnt_ff;
            trim_type    trim;
            wire logic   adj_hit = adj_cfg_ff[`F_ADJ_EN] && (adj_cnt_ff >= adj_int_ff);
            wire logic   wr_cfg  = reg_wr && (reg_addr == `A_ADJ_CFG + 8'(2 * d));
            wire logic   wr_int  = reg_wr && (reg_addr == `A_ADJ_INT + 8'(2 * d));

            // Periodic one nanosecond correction at the programmed interval.
            assign trim = !adj_hit ? trim_none : // RL2
                          (adj_cfg_ff[`F_ADJ_DIR] ? trim_minus : trim_plus);

            // Interval counter restarts after each correction.
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    adj_cfg_ff <= '0;
                    adj_int_ff <= '0;
                    adj_cnt_ff <= '0;
                end
                else
                begin
                    if (wr_cfg)
                        adj_cfg_ff <= reg_wdata[1:0];
                    if (wr_int)
                        adj_int_ff <= reg_wdata;
                    adj_cnt_ff <= (adj_hit || !adj_cfg_ff[`F_ADJ_EN]) ? 32'h0 : adj_cnt_ff + 32'h1;
                end
            end

            // Lowest controller wins when several set the same domain.
            always_comb
            begin
                dom_abs[d]     = 1'b0;
                dom_add[d]     = 1'b0;
                dom_set_sec[d] = '0;
                dom_set_ns[d]  = '0;
                for (int c = NUM_CTRL - 1; c >= 0; c--)
                begin
                    if ((ld_req[c] || dl_req[c]) && ctrl_dom[c] == 2'(d))
                    begin
                        dom_abs[d]     = ld_req[c]; // RL3
                        dom_add[d]     = dl_req[c];
                        dom_set_sec[d] = ld_req[c] ? ctrl_sec[c] : '0;
                        dom_set_ns[d]  = ld_req[c] ? ctrl_ns[c] : ctrl_dns[c];
                    end
                end
            end

            tod_counter u_cnt
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .trim    (trim),
                .set_abs (dom_abs[d]),
                .set_add (dom_add[d]),
                .set_sec (dom_set_sec[d]),
                .set_ns  (dom_set_ns[d]),
                .sec_ff  (dom_sec[d]),
                .ns_ff   (dom_ns[d])
            );

            assign dom_rd[d] = (reg_addr == `A_ADJ_CFG + 8'(2 * d)) ? {30'h0, adj_cfg_ff} :
                               (reg_addr == `A_ADJ_INT + 8'(2 * d)) ? adj_int_ff : 32'h0;
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Load/store controllers
    // -------------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NUM_CTRL; c++) // RL4
        begin : g_ctrl
            localparam logic HAS_PIN = (c < NUM_PINS);
            localparam logic [`ADDR_W-1:0] BASE = `A_CTRL_BASE + 8'(c * `A_STRIDE);
            logic [5:0]        cfg_ff;
            logic              busy_ff;
            logic [`SEC_W-1:0] sec_ff;
            logic [`NS_W-1:0]  ns_ff;
            logic [`NSF_W-1:0] nsf_ff;
            logic [`NS_W-1:0]  whi_ff;
            logic [`NS_W-1:0]  wlo_ff;
            logic [`NS_W-1:0]  dns_ff;
            logic [`NS_W-1:0]  wcnt_ff;
            logic              lvl_ff;
            logic              pend_ff;
            action_type        act;
            wire logic sel   = reg_addr[7:3] == BASE[7:3];
            wire logic wr_sel = reg_wr && sel;
            wire logic [2:0] off = reg_addr[2:0];
            wire logic wr_c  = wr_sel && off == `O_CFG;
            wire logic go    = wr_c && reg_wdata[`F_GO];
            wire logic sync  = cfg_ff[`F_SYNC] && HAS_PIN; // RL19
            wire logic inv   = cfg_ff[`F_INV];
            wire logic pin_now  = HAS_PIN ? pin_s2_ff[c % NUM_PINS] : 1'b0;
            wire logic pin_prev = HAS_PIN ? pin_s3_ff[c % NUM_PINS] : 1'b0;
            wire logic edge_det = inv ? (pin_prev && !pin_now) : (!pin_prev && pin_now);  // RL10
            wire logic is_clk   = (act == act_clock) && HAS_PIN;
            wire logic fire     = busy_ff && !is_clk && (!sync || edge_det || act == act_delta);  // RL5 RL9
            wire logic [1:0] dsel = cfg_ff[`F_DOM_HI:`F_DOM_LO];
            wire logic [1:0] dom  = (dsel < 2'(NUM_DOM)) ? dsel : 2'h0;        // RL18
            wire logic [`NS_W-1:0] cur_ns = dom_ns[dom];
            wire logic pulse_start = cur_ns == wlo_ff; // RL12
            wire logic wave_tick   = wcnt_ff <= `CLK_PERIOD_NS;
            wire logic go_active   = is_clk && busy_ff &&
                                     (sync ? (!pend_ff && !lvl_ff && pulse_start) : (!lvl_ff && wave_tick));
            wire logic go_idle     = is_clk && busy_ff && lvl_ff && wave_tick; // RL11

            assign act         = action_type'(cfg_ff[`F_ACT_HI:`F_ACT_LO]);   // RL6
            assign ld_req[c]   = fire && act == act_load;
            assign dl_req[c]   = fire && act == act_delta; // RL13
            assign ctrl_dom[c] = dom;
            assign ctrl_sec[c] = sec_ff;
            assign ctrl_ns[c]  = ns_ff;
            assign ctrl_dns[c] = dns_ff;
            assign evt_set[c]  = fire || go_active; // RL14

            // Configuration, stored time and waveform engine.
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    cfg_ff  <= '0;
                    busy_ff <= 1'b0;
                    sec_ff  <= '0;
                    ns_ff   <= '0;
                    nsf_ff  <= '0;
                    whi_ff  <= '0;
                    wlo_ff  <= '0;
                    dns_ff  <= '0;
                    wcnt_ff <= '0;
                    lvl_ff  <= 1'b0;
                    pend_ff <= 1'b0;
                end
                else
                begin
                    if (wr_c)
                        cfg_ff <= reg_wdata[5:0];
                    if (wr_sel && off == `O_SEC_LO)
                        sec_ff[31:0] <= reg_wdata; // RL7
                    if (wr_sel && off == `O_SEC_HI)
                        sec_ff[`SEC_W-1:32] <= reg_wdata[15:0];
                    if (wr_sel && off == `O_NS)
                        ns_ff <= reg_wdata[`NS_W-1:0];
                    if (wr_sel && off == `O_WAVE_HI)
                        whi_ff <= reg_wdata[`NS_W-1:0];
                    if (wr_sel && off == `O_WAVE_LO)
                        wlo_ff <= reg_wdata[`NS_W-1:0];
                    if (wr_sel && off == `O_DELTA_NS)
                        dns_ff <= reg_wdata[`NS_W-1:0];
                    if (fire && act == act_store)
                    begin
                        sec_ff <= dom_sec[dom];
                        ns_ff  <= cur_ns;
                        nsf_ff <= free_running_ns_timer_ff; // RL8
                    end
                    // One-shot actions end on execution; a clock runs until stopped.
                    busy_ff <= go ? 1'b1 : ((fire || (go_idle && sync)) ? 1'b0 : busy_ff);
                    pend_ff <= go ? 1'b0 : (go_active ? 1'b1 : pend_ff);
                    if (go_active)
                        lvl_ff <= 1'b1;
                    else if (go_idle || !busy_ff)
                        lvl_ff <= 1'b0;
                    if (go_active)
                        wcnt_ff <= whi_ff;
                    else if (go_idle)
                        wcnt_ff <= wlo_ff;
                    else if (!wave_tick)
                        wcnt_ff <= wcnt_ff - `CLK_PERIOD_NS;
                    else
                        wcnt_ff <= '0;
                end
            end

            assign ctrl_rd[c] = !sel ? 32'h0 :
                (off == `O_CFG)     ? {22'h0, busy_ff, 3'h0, cfg_ff} :
                (off == `O_SEC_LO)  ? sec_ff[31:0] :
                (off == `O_SEC_HI)  ? {16'h0, sec_ff[`SEC_W-1:32]} :
                (off == `O_NS)      ? {2'h0, ns_ff} :
                (off == `O_NSF)     ? nsf_ff :
                (off == `O_WAVE_HI) ? {2'h0, whi_ff} :
                (off == `O_WAVE_LO) ? {2'h0, wlo_ff} : {2'h0, dns_ff};

            if (HAS_PIN)
            begin : g_pin
                // Active level follows polarity; pin is driven whenever the clock action is selected.
                always_ff @(posedge clk_sys or posedge rst)
                begin
                    if (rst)
                    begin
                        sync_pin_out_ff[c]  <= 1'b0;
                        sync_pin_oe_n_ff[c] <= 1'b1;
                    end
                    else
                    begin
                        sync_pin_out_ff[c]  <= (go_active || (lvl_ff && !go_idle)) ^ inv;  // RL10
                        sync_pin_oe_n_ff[c] <= !is_clk;
                    end
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Events, port domains and read data
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            evt_stat_ff   <= '0;
            evt_mask_ff   <= '0;
            ctrl_event_ff <= '0;
            port_dom_ff   <= '0; // RL18
        end
        else
        begin
            // A new event wins over a write-one clear in the same cycle.
            evt_stat_ff   <= (evt_stat_ff & ~(wr_evt ? reg_wdata[NUM_CTRL-1:0] : '0)) | evt_set;
            if (wr_mask)
                evt_mask_ff <= reg_wdata[NUM_CTRL-1:0];
            ctrl_event_ff <= evt_stat_ff & evt_mask_ff; // RL15
            if (wr_pdom)
                port_dom_ff <= reg_wdata;
        end
    end

    always_comb
    begin
        rd_mux = 32'h0;
        for (int i = 0; i < NUM_CTRL; i++)
            rd_mux = rd_mux | ctrl_rd[i];
        for (int i = 0; i < NUM_DOM; i++)
            rd_mux = rd_mux | dom_rd[i];
        if (rd_evt)
            rd_mux = 32'(evt_stat_ff);
        if (reg_addr == `A_EVT_MASK)
            rd_mux = 32'(evt_mask_ff);
        if (reg_addr == `A_PORT_DOM)
            rd_mux = port_dom_ff;
        if (reg_addr == `A_TIME_BASE)
            rd_mux = {2'h0, dom_ns[0]};
    end

    // Read data stand for exactly one cycle after the strobe.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata_ff              <= '0;
            time_seconds_value_ff     <= '0;
            time_nanoseconds_value_ff <= '0;
        end
        else
        begin
            reg_rdata_ff              <= reg_rd ? rd_mux : 32'h0;
            time_seconds_value_ff     <= dom_sec[0];
            time_nanoseconds_value_ff <= dom_ns[0];
        end
    end
endmodule

//--- tod_consts.svh
// Constants and register map for the time-of-day load/store block.
// Assumes inclusion by bare name from every design file that needs it.
// Summary of operation
// RL1: Counters advance nominal period plus trim each cycle.
// RL2: Delta adjust adds periodic plus or minus nanosecond.
// RL3: Absolute load sets full time in counters.
// RL4: Five controllers; four pinned, fifth pinless.
// RL5: Load or store, immediately or on pin edge.
// RL6: Actions: load, delta, store, clock or pulse.
// RL7: Forty-eight bit seconds, thirty bit nanoseconds held.
// RL8: Store captures free timer; timer never loaded.
// RL9: Sync load or store waits for edge; clock sync gives pulse.
// RL10: Inverse polarity uses falling edges both ways.
// RL11: High setting: clock high time, pulse width.
// RL12: Low setting: clock low time, pulse delay.
// RL13: Delta command adds value to current time.
// RL14: Each operation raises event; clock at active edge.
// RL15: Per-controller event mask; status readable.
// RL16: Software enables pin overlay before pinned use.
// RL17: Software sets two controllers store-on-edge for TC.
// RL18: Three domains; controller assignable; ports default zero.
// RL19: Pinless controller does immediate load, delta, store only.
// RL20: Nanoseconds wrap at one billion into seconds.
`ifndef TOD_CONSTS_SVH
`define TOD_CONSTS_SVH

// -----------------------------------------------------------------------------
// Sizes and timing
// -----------------------------------------------------------------------------
`define SEC_W        48
`define NS_W         30
`define NSF_W        32
`define NS_PER_SEC   30'h3b9aca00
`define CLK_PERIOD_NS 30'h00a
`define NUM_CTRL     5
`define NUM_PINS     4
`define NUM_DOM      3

// -----------------------------------------------------------------------------
// Register map, word addresses on the plain port
// -----------------------------------------------------------------------------
`define ADDR_W       8
`define A_CTRL_BASE  8'h00
`define A_STRIDE     8'h08
`define O_CFG        3'h0
`define O_SEC_LO     3'h1
`define O_SEC_HI     3'h2
`define O_NS         3'h3
`define O_NSF        3'h4
`define O_WAVE_HI    3'h5
`define O_WAVE_LO    3'h6
`define O_DELTA_NS   3'h7
`define A_ADJ_CFG    8'h40
`define A_ADJ_INT    8'h41
`define A_EVT_STAT   8'h48
`define A_EVT_MASK   8'h49
`define A_PORT_DOM   8'h4a
`define A_TIME_BASE  8'h50

// CFG fields.
`define F_ACT_LO     0
`define F_ACT_HI     1
`define F_SYNC       2
`define F_INV        3
`define F_DOM_LO     4
`define F_DOM_HI     5
`define F_GO         8
`define F_BUSY       9
`define F_ADJ_EN     0
`define F_ADJ_DIR    1

`endif

//--- tod_pkg.sv
// Types shared by the time-of-day block files.
// Assumes the constants header is compiled with it.
package tod_pkg;
    typedef enum logic [1:0] {act_load, act_delta, act_store, act_clock} action_type;
    typedef enum logic [1:0] {trim_none, trim_plus, trim_minus} trim_type;
endpackage

//--- tod_counter.sv
// One time counter instance: seconds and nanoseconds with trim and load.
// Assumes a synchronous set pulse and one trim request per cycle.
`timescale 1ns/10ps
`include "tod_consts.svh"
module tod_counter
#(
    parameter logic [`NS_W-1:0] PERIOD_NS = `CLK_PERIOD_NS
)
(
    // Clock and reset.
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Trim, absolute set and delta add.
    input  wire tod_pkg::trim_type  trim,
    input  wire logic               set_abs,
    input  wire logic               set_add,
    input  wire logic [`SEC_W-1:0]  set_sec,
    input  wire logic [`NS_W-1:0]   set_ns,
    // Current time.
    output logic [`SEC_W-1:0]       sec_ff,
    output logic [`NS_W-1:0]        ns_ff
);
    import tod_pkg::*;

    logic [`NS_W:0]   step;
    logic [`NS_W+1:0] sum_ns;
    logic [`NS_W+1:0] add_ns;
    logic             wrap;
    logic             add_wrap;
    logic [`SEC_W-1:0] nxt_sec;
    logic [`NS_W-1:0]  nxt_ns;

    // Per-cycle step is the nominal period with a one nanosecond trim.
    assign step = (trim == trim_plus)  ? {1'b0, PERIOD_NS} + 31'h1 : // RL1
                  (trim == trim_minus) ? {1'b0, PERIOD_NS} - 31'h1 :
                                         {1'b0, PERIOD_NS};
    assign sum_ns   = {2'b00, ns_ff} + {1'b0, step};
    assign wrap     = sum_ns >= {2'b00, `NS_PER_SEC}; // RL20
    assign add_ns   = sum_ns + {2'b00, set_ns}; // RL1
    assign add_wrap = add_ns >= {2'b00, `NS_PER_SEC};

    // Absolute set overrides, a delta add keeps carries, else normal advance.
    assign nxt_sec = set_abs ? set_sec :                                       // RL3
                     set_add ? sec_ff + set_sec + {{(`SEC_W-1){1'b0}}, add_wrap} : // RL13
                     sec_ff + {{(`SEC_W-1){1'b0}}, wrap};
    assign nxt_ns  = set_abs ? set_ns :
                     set_add ? (add_wrap ? add_ns[`NS_W-1:0] - `NS_PER_SEC : add_ns[`NS_W-1:0]) :
                     (wrap ? sum_ns[`NS_W-1:0] - `NS_PER_SEC : sum_ns[`NS_W-1:0]);

    // Time registers.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sec_ff <= '0;
            ns_ff  <= '0;
        end
        else
        begin
            sec_ff <= nxt_sec;
            ns_ff  <= nxt_ns;
        end
    end
endmodule

//--- tod_sync_source.sv
// Far-side timing equipment driving the sync pins.
// Assumes one-cycle edge requests from the bench.
`timescale 1ns/10ps
module tod_sync_source
(
    // Clock and requests.
    input  wire logic       clk_sys,
    input  wire logic [3:0] rise_req,
    input  wire logic [3:0] fall_req,
    // Pin levels, idle low.
    output logic [3:0]      pin
);
    // Edges of both directions, so inverse polarity is exercised too.
    initial pin = 4'h0;
    always @(posedge clk_sys)
        pin <= (pin | rise_req) & ~fall_req;
endmodule

//--- tod_loadstore_properties.sv
// Port checker for the time-of-day block.
// Assumes the register map of the constants header.
`timescale 1ns/10ps
`include "tod_consts.svh"
module tod_loadstore_properties
#(
    parameter int NUM_CTRL = 5
)
(
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic [7:0]          reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [31:0]         reg_rdata_ff,
    input wire logic [3:0]          sync_pin_in,
    input wire logic [NUM_CTRL-1:0] ctrl_event_ff,
    input wire logic [47:0]         time_seconds_value_ff,
    input wire logic [29:0]         time_nanoseconds_value_ff
);
    logic [4:0] mask_ff;
    logic [3:0] quiet_ff;
    logic [3:0] pin_ff;
    wire logic [29:0] ns = time_nanoseconds_value_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Quiet time: loads only follow a write or a pin edge, so plain advance holds then.
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            mask_ff  <= 5'h00;
            quiet_ff <= 4'h0;
            pin_ff   <= 4'h0;
        end
        else
        begin
            mask_ff  <= (reg_wr && reg_addr == 8'h49) ? reg_wdata[4:0] : mask_ff;
            quiet_ff <= (reg_wr || sync_pin_in != pin_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
            pin_ff   <= sync_pin_in;
        end
    property p_ns_range; ns < `NS_PER_SEC; endproperty
    a_ns_range: assert property (p_ns_range) else $error("ns out of range");
    property p_adv; quiet_ff == 4'hf && $past(ns) < 30'h3b9ac9f0 |-> ns - $past(ns) inside {9, 10, 11}; endproperty
    a_adv: assert property (p_adv) else $error("bad advance");
    property p_wrap; quiet_ff == 4'hf && $past(ns) > 30'h3b9ac9f4 && ns < 30'h00c
        |-> time_seconds_value_ff == $past(time_seconds_value_ff) + 48'h1; endproperty
    a_wrap: assert property (p_wrap) else $error("no carry");
    property p_rd_zero; !$past(reg_rd) |-> reg_rdata_ff == 32'h0; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
    property p_rd_mask; reg_rd && reg_addr == 8'h49 |=> reg_rdata_ff == {27'h0, mask_ff}; endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("mask readback");
    property p_mask_off; reg_wr && reg_addr == 8'h49 && reg_wdata[4:0] == 5'h0 |=> ##1 ctrl_event_ff == 5'h0; endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked event");
    property p_ev4_cause; $rose(ctrl_event_ff[4]) |-> ($past(reg_wr, 3) && $past(reg_addr, 3) == 8'h20)
        || ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h49); endproperty
    a_ev4_cause: assert property (p_ev4_cause) else $error("event without cause");
    property p_ctrl4_go; reg_wr && reg_addr == 8'h20 && reg_wdata[8] && reg_wdata[1:0] != 2'h3 && mask_ff[4]
        |-> ##3 ctrl_event_ff[4]; endproperty
    a_ctrl4_go: assert property (p_ctrl4_go) else $error("no event");
endmodule
bind tod_loadstore tod_loadstore_properties #(.NUM_CTRL(NUM_CTRL)) i_chk (.*);

//--- tod_loadstore_tb.sv
// Self-checking bench for the time-of-day block.
// Assumes the sync source model and checker compiled before it.
`timescale 1ns/10ps
`define CHK(n, e, s) chk(n, 64'(e), 64'(s))
module tod_loadstore_tb;
    logic        clk_sys = 0;
    logic        rst = 1;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic [31:0] reg_rdata_ff;
    logic [3:0]  rise_req = 0;
    logic [3:0]  fall_req = 0;
    logic [3:0]  pin, pin_out, oe_n;
    logic [4:0]  ev;
    logic [47:0] sec, s;
    logic [29:0] ns;
    logic [31:0] seed = 32'hf1639c8c;
    logic [31:0] a, b;
    int          err_count = 0;
    int          check_count = 0;
    int          n;
    // The pin level is whoever drives it; the block wins while its enable is low.
    wire  [3:0]  lvl = (pin & oe_n) | (pin_out & ~oe_n);
    always #5 clk_sys = ~clk_sys;
    tod_sync_source i_src (.*);
    tod_loadstore i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .sync_pin_in(lvl),
        .sync_pin_out_ff(pin_out), .sync_pin_oe_n_ff(oe_n), .ctrl_event_ff(ev),
        .time_seconds_value_ff(sec), .time_nanoseconds_value_ff(ns));
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input string nm, input logic [63:0] e, input logic [63:0] v);
        check_count++;
        if (v !== e)
        begin
            $display("MISMATCH %s exp %0h got %0h", nm, e, v);
            err_count++;
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1;
        reg_addr  <= ad;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1;
        reg_addr <= ad;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1 d = reg_rdata_ff;
    endtask
    task pulse(input logic [3:0] r, input logic [3:0] f);
        @(posedge clk_sys);
        rise_req <= r;
        fall_req <= f;
        @(posedge clk_sys);
        rise_req <= 0;
        fall_req <= 0;
    endtask
    // Bounded wait for an event flag; a timeout closes the run.
    task wait_ev(input int i);
        n = 0;
        while (ev[i] !== 1'b1 && n < 300)
        begin
            @(posedge clk_sys);
            n++;
        end
        `CHK("event", 1, ev[i]);
        if (n == 300)
            end_sim;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 0;
        rd(8'h7f, a);
        `CHK("unmapped", 0, a);
        wr(8'h49, 32'h1f);
        rd(8'h50, a);
        repeat (20) @(posedge clk_sys);
        rd(8'h50, b);
        `CHK("advance", 220, b - a);
        wr(8'h41, 32'h4);
        for (int d = 1; d < 4; d += 2)
        begin
            wr(8'h40, d);
            rd(8'h50, a);
            repeat (20) @(posedge clk_sys);
            rd(8'h50, b);
            `CHK("adjust", 1, (d == 1) ? (b - a inside {[223:226]}) : (b - a inside {[214:217]}));
        end
        wr(8'h40, 0);
        repeat (3)
        begin
            s = 48'({xs(), xs()});
            wr(8'h21, s[31:0]);
            wr(8'h22, {16'h0, s[47:32]});
            wr(8'h23, 32'h3b9ac938);
            wr(8'h20, 32'h100);
            wait_ev(4);
            repeat (40) @(posedge clk_sys);
            `CHK("wrap_sec", s + 1, sec);
            wr(8'h48, 32'h10);
            repeat (2) @(posedge clk_sys);
            `CHK("clear", 0, ev[4]);
        end
        b = xs() & 32'hfffff;
        wr(8'h27, b);
        rd(8'h50, a);
        wr(8'h20, 32'h101);
        repeat (5) @(posedge clk_sys);
        rd(8'h50, s[31:0]);
        `CHK("delta", 90, s[31:0] - a - b);
        wr(8'h20, 32'h102);
        repeat (5) @(posedge clk_sys);
        rd(8'h21, a);
        `CHK("store_sec", sec[31:0], a);
        rd(8'h24, a);
        wr(8'h24, ~a);
        rd(8'h24, b);
        `CHK("free_timer", a, b);
        pulse(4'h2, 4'h0);
        for (int p = 0; p < 2; p++)
        begin
            wr(8'(8 * p), 32'h106 | 32'(p << 3));
            repeat (20) @(posedge clk_sys);
            `CHK("sync_wait", 0, ev[p]);
            a = ns;
            pulse(p ? 4'h0 : 4'h1, p ? 4'h2 : 4'h0);
            wait_ev(p);
            rd(8'(8 * p + 3), b);
            `CHK("sync_ns", 1, b - a inside {[10:150]});
        end
        wr(8'h15, 32'd30);
        wr(8'h16, 32'd50);
        wr(8'h10, 32'h103);
        wait_ev(2);
        n = 0;
        repeat (40)
        begin
            @(posedge clk_sys);
            n += pin_out[2];
        end
        `CHK("clock_high", 15, n);
        `CHK("clock_oe", 0, oe_n[2]);
        end_sim;
    end
endmodule
